// [hw/spd_bit_capture.sv]
// Link-side capture: samples the data line on each rising serial clock edge.
// Assumes scl_clk is the bus clock; it may stop between frames.
`timescale 1ns/1ps
module spd_bit_capture (
    input wire logic scl_clk,
    input wire logic rst_b,
    input wire logic sda_in,
    output logic bit_value,
    output logic bit_toggle
);
    logic bit_value_reg;
    logic bit_toggle_reg;

    // Serial clock may be idle during reset, so reset without it: value high, toggle low
    always_ff @(posedge scl_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_value_reg <= 1'b1;
            bit_toggle_reg <= 1'b0;
        end else begin
            bit_value_reg <= sda_in;
            bit_toggle_reg <= ~bit_toggle_reg;
        end
    end

    assign bit_value = bit_value_reg;
    assign bit_toggle = bit_toggle_reg;
endmodule : spd_bit_capture

// [hw/spd_defs.svh]
// Constants for the presence-detect serial store: offsets, reset contents, timing.
// Assumes inclusion by bare name from the design files.
`ifndef SPD_DEFS_SVH
`define SPD_DEFS_SVH

// Clock rate and program cycle time
`define SPD_CLK_HZ 25000000
`define SPD_INTERNAL_PROGRAM_TIME_MS 10
`define SPD_PROG_CYCLES ((`SPD_INTERNAL_PROGRAM_TIME_MS * `SPD_CLK_HZ) / 1000)

// Device select layout and page size
`define SPD_TYPE_CODE 4'ha
`define SPD_TYPE_MSB 7
`define SPD_TYPE_LSB 4
`define SPD_RW_BIT 0
`define SPD_PAGE_BYTES 16

// Descriptor offsets
`define SPD_OFS_USED_BYTE_COUNT 8'h00
`define SPD_OFS_TOTAL_STORE_SIZE 8'h01
`define SPD_OFS_MEMORY_TYPE 8'h02
`define SPD_OFS_ROW_ADDRESS_BITS 8'h03
`define SPD_OFS_COLUMN_ADDRESS_BITS 8'h04
`define SPD_OFS_MODULE_RANK_COUNT 8'h05
`define SPD_OFS_DATA_WIDTH_LOW 8'h06
`define SPD_OFS_DATA_WIDTH_HIGH 8'h07
`define SPD_OFS_INTERFACE_LEVEL 8'h08
`define SPD_OFS_CYCLE_TIME_LONG_LATENCY 8'h09
`define SPD_OFS_ACCESS_TIME_LONG_LATENCY 8'h0a
`define SPD_OFS_CONFIG_TYPE 8'h0b
`define SPD_OFS_REFRESH_RATE_TYPE 8'h0c
`define SPD_OFS_PRIMARY_COMPONENT_WIDTH 8'h0d
`define SPD_OFS_CHECK_COMPONENT_WIDTH 8'h0e
`define SPD_OFS_COLUMN_TO_COLUMN_DELAY 8'h0f
`define SPD_OFS_BURST_LENGTHS 8'h10
`define SPD_OFS_COMPONENT_BANK_COUNT 8'h11
`define SPD_OFS_READ_LATENCIES 8'h12
`define SPD_OFS_SELECT_LATENCY 8'h13
`define SPD_OFS_WRITE_ENABLE_LATENCY 8'h14
`define SPD_OFS_MODULE_ATTRIBUTES 8'h15
`define SPD_OFS_COMPONENT_ATTRIBUTES 8'h16
`define SPD_OFS_CYCLE_TIME_SHORT_LATENCY 8'h17

// Descriptor reset contents
`define SPD_RST_USED_BYTE_COUNT 8'h80
`define SPD_RST_TOTAL_STORE_SIZE 8'h08
`define SPD_RST_MEMORY_TYPE 8'h04
`define SPD_RST_ROW_BITS_12 8'h0c
`define SPD_RST_ROW_BITS_13 8'h0d
`define SPD_RST_COLUMN_ADDRESS_BITS 8'h0a
`define SPD_RST_MODULE_RANK_COUNT 8'h02
`define SPD_RST_DATA_WIDTH_LOW 8'h40
`define SPD_RST_DATA_WIDTH_HIGH 8'h00
`define SPD_RST_INTERFACE_LEVEL 8'h01
`define SPD_RST_CONFIG_TYPE 8'h00
`define SPD_RST_PRIMARY_COMPONENT_WIDTH 8'h08
`define SPD_RST_CHECK_COMPONENT_WIDTH 8'h00
`define SPD_RST_COLUMN_TO_COLUMN_DELAY 8'h01
`define SPD_RST_BURST_LENGTHS 8'h8f
`define SPD_RST_COMPONENT_BANK_COUNT 8'h04
`define SPD_RST_READ_LATENCIES 8'h06
`define SPD_RST_SELECT_LATENCY 8'h01
`define SPD_RST_WRITE_ENABLE_LATENCY 8'h01
`define SPD_RST_MODULE_ATTRIBUTES 8'h00
`define SPD_RST_COMPONENT_ATTRIBUTES 8'h0e
`define SPD_RST_UNDEFINED 8'h00

`endif

// [hw/spd_pkg.sv]
// Types shared by the presence-detect serial store.
// Assumes spd_defs.svh is on the include path.
package spd_pkg;
    typedef enum logic [3:0] {
        SPD_IDLE,
        SPD_DEVSEL,
        SPD_ACK_DEV,
        SPD_ADDR,
        SPD_ACK_ADDR,
        SPD_WDATA,
        SPD_ACK_W,
        SPD_RDATA,
        SPD_RACK,
        SPD_WAIT_STOP
    } spd_state_t;
endpackage : spd_pkg

// [hw/spd_serial_eeprom_slave.sv]
// Two-wire serial presence-detect store, slave end, with 256-byte array.
// Assumes open-drain pads outside; scl_clk is the bus clock, clk is 25 MHz.
//
// What this block does
// - Start plus select with read bit returns byte at the address pointer.
// - Dummy write: select with write bit, then byte loaded into the pointer.
// - Repeated start plus select with read bit returns byte at loaded address.
// - Reads continue with consecutive bytes while the master keeps acknowledging.
// - Byte write opens with start and select; accepted only while write_protect_pin low.
// - Page write has same opening, needs pin low, at most 16 data bytes.
// - Stop ending a write starts a program cycle lasting at most 10 ms.
// - During program cycle the data line stays released and address is not acknowledged.
// - Byte 0 reads 0x80, 128 bytes used.
// - Byte 1 reads 0x08, 256-byte store.
// - Byte 3 reads 0x0C or 0x0D by row-bit variant.
// - Byte 4 reads 0x0A, ten column bits.
// - Byte 6 reads 0x40, byte 7 reads 0x00.
// - Byte 14 reads 0x00, no check width.
// - Byte 15 reads 0x01, one clock column delay.
// - Byte 17 reads 0x04, four banks.
// - Byte 22 reads 0x0E.
// - Select byte MSB first: type code, three select pins, read/write bit.
// - In writes, address and each byte are acknowledged on the ninth clock.
// - Master not acknowledging a read byte ends transmission until stop.
`timescale 1ns/1ps
`include "spd_defs.svh"
module spd_serial_eeprom_slave #(
    parameter int unsigned PROG_CYCLES = `SPD_PROG_CYCLES,
    parameter logic ROW_BITS_13 = 1'b0,
    parameter logic [7:0] CYCLE_TIME_LONG = 8'h00,
    parameter logic [7:0] ACCESS_TIME_LONG = 8'h00,
    parameter logic [7:0] REFRESH_RATE = 8'h00,
    parameter logic [7:0] CYCLE_TIME_SHORT = 8'h00
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic write_protect_pin,
    input wire logic select_addr_pin_low,
    input wire logic select_addr_pin_mid,
    input wire logic select_addr_pin_high,
    output logic sda_out,
    output logic sda_oe,
    output logic program_busy
);
    localparam int BUSY_W = $clog2(PROG_CYCLES + 1);
    localparam int PAGE = `SPD_PAGE_BYTES;

    // Descriptor array and page staging buffer
    logic [7:0] mem [0:255];
    logic [7:0] page_buf [0:PAGE-1];
    logic [PAGE-1:0] page_mask_reg;

    spd_pkg::spd_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic rw_reg;
    logic [BUSY_W-1:0] busy_cnt_reg;
    logic program_busy_reg;
    logic sda_oe_reg;
    logic sda_out_reg;

    logic scl_d_reg;
    logic sda_d_reg;
    logic tgl_d_reg;
    logic tgl_dd_reg;

    logic scl_s;
    logic sda_s;
    logic bit_s;
    logic tgl_s;
    logic wp_s;
    logic [2:0] sa_s;
    logic cap_value;
    logic cap_toggle;

    logic start_det;
    logic stop_det;
    logic scl_fall;
    logic bit_evt;
    logic [7:0] rx_byte;
    logic dev_hit;
    logic commit;

    // Bit sampling on the bus clock
    spd_bit_capture u_capture (
        .scl_clk(scl_clk),
        .rst_b(rst_b),
        .sda_in(sda_in),
        .bit_value(cap_value),
        .bit_toggle(cap_toggle)
    );

    // Bus lines seen as levels for start, stop and falling clock
    spd_sync #(.WIDTH(2), .INIT(2'b11)) u_sync_bus (
        .clk(clk),
        .rst_b(rst_b),
        .d({scl_clk, sda_in}),
        .q({scl_s, sda_s})
    );

    spd_sync #(.WIDTH(2), .INIT(2'b10)) u_sync_bit (
        .clk(clk),
        .rst_b(rst_b),
        .d({cap_value, cap_toggle}),
        .q({bit_s, tgl_s})
    );

    spd_sync #(.WIDTH(4), .INIT(4'h8)) u_sync_pins (
        .clk(clk),
        .rst_b(rst_b),
        .d({write_protect_pin, select_addr_pin_high, select_addr_pin_mid,
            select_addr_pin_low}),
        .q({wp_s, sa_s})
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            tgl_d_reg <= 1'b0;
            tgl_dd_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            tgl_d_reg <= tgl_s;
            tgl_dd_reg <= tgl_d_reg;
        end
    end

    // Start and stop: data edge while the clock stays high
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign scl_fall = scl_d_reg & ~scl_s;
    // Event one cycle behind the value, so the value has settled
    assign bit_evt = tgl_d_reg ^ tgl_dd_reg;
    assign rx_byte = {rx_reg[6:0], bit_s};
    assign dev_hit = rx_byte[`SPD_TYPE_MSB:1] == {`SPD_TYPE_CODE, sa_s};
    // Only a stop commits; a repeated start drops staged bytes
    assign commit = stop_det & (|page_mask_reg);

    // Power-up contents of the descriptor
    function automatic logic [7:0] spd_reset_byte(input logic [7:0] ofs);
        logic [7:0] val;
        val = `SPD_RST_UNDEFINED;
        case (ofs)
            `SPD_OFS_USED_BYTE_COUNT: val = `SPD_RST_USED_BYTE_COUNT;
            `SPD_OFS_TOTAL_STORE_SIZE: val = `SPD_RST_TOTAL_STORE_SIZE;
            `SPD_OFS_MEMORY_TYPE: val = `SPD_RST_MEMORY_TYPE;
            `SPD_OFS_ROW_ADDRESS_BITS: begin
                val = ROW_BITS_13 ? `SPD_RST_ROW_BITS_13 : `SPD_RST_ROW_BITS_12;
            end
            `SPD_OFS_COLUMN_ADDRESS_BITS: val = `SPD_RST_COLUMN_ADDRESS_BITS;
            `SPD_OFS_MODULE_RANK_COUNT: val = `SPD_RST_MODULE_RANK_COUNT;
            `SPD_OFS_DATA_WIDTH_LOW: val = `SPD_RST_DATA_WIDTH_LOW;
            `SPD_OFS_DATA_WIDTH_HIGH: val = `SPD_RST_DATA_WIDTH_HIGH;
            `SPD_OFS_INTERFACE_LEVEL: val = `SPD_RST_INTERFACE_LEVEL;
            `SPD_OFS_CYCLE_TIME_LONG_LATENCY: val = CYCLE_TIME_LONG;
            `SPD_OFS_ACCESS_TIME_LONG_LATENCY: val = ACCESS_TIME_LONG;
            `SPD_OFS_CONFIG_TYPE: val = `SPD_RST_CONFIG_TYPE;
            `SPD_OFS_REFRESH_RATE_TYPE: val = REFRESH_RATE;
            `SPD_OFS_PRIMARY_COMPONENT_WIDTH: val = `SPD_RST_PRIMARY_COMPONENT_WIDTH;
            `SPD_OFS_CHECK_COMPONENT_WIDTH: val = `SPD_RST_CHECK_COMPONENT_WIDTH;
            `SPD_OFS_COLUMN_TO_COLUMN_DELAY: val = `SPD_RST_COLUMN_TO_COLUMN_DELAY;
            `SPD_OFS_BURST_LENGTHS: val = `SPD_RST_BURST_LENGTHS;
            `SPD_OFS_COMPONENT_BANK_COUNT: val = `SPD_RST_COMPONENT_BANK_COUNT;
            `SPD_OFS_READ_LATENCIES: val = `SPD_RST_READ_LATENCIES;
            `SPD_OFS_SELECT_LATENCY: val = `SPD_RST_SELECT_LATENCY;
            `SPD_OFS_WRITE_ENABLE_LATENCY: val = `SPD_RST_WRITE_ENABLE_LATENCY;
            `SPD_OFS_MODULE_ATTRIBUTES: val = `SPD_RST_MODULE_ATTRIBUTES;
            `SPD_OFS_COMPONENT_ATTRIBUTES: val = `SPD_RST_COMPONENT_ATTRIBUTES;
            `SPD_OFS_CYCLE_TIME_SHORT_LATENCY: val = CYCLE_TIME_SHORT;
            default: val = `SPD_RST_UNDEFINED;
        endcase
        return val;
    endfunction : spd_reset_byte

    // Whether the pad pulls low during the coming clock-low phase
    function automatic logic spd_pull_low(input spd_pkg::spd_state_t st,
                                          input logic msb);
        logic pull;
        pull = 1'b0;
        case (st)
            spd_pkg::SPD_ACK_DEV: pull = 1'b1;
            spd_pkg::SPD_ACK_ADDR: pull = 1'b1;
            spd_pkg::SPD_ACK_W: pull = 1'b1;
            spd_pkg::SPD_RDATA: pull = ~msb;
            default: pull = 1'b0;
        endcase
        return pull;
    endfunction : spd_pull_low

    // Protocol sequencer, address pointer and page staging
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= spd_pkg::SPD_IDLE;
            bit_cnt_reg <= 3'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'hff;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            page_mask_reg <= '0;
        end else if (start_det) begin
            // Plain or repeated start: fresh select byte
            state_reg <= spd_pkg::SPD_DEVSEL;
            bit_cnt_reg <= 3'h0;
            page_mask_reg <= '0;
        end else if (stop_det) begin
            // Standby until the next start
            state_reg <= spd_pkg::SPD_IDLE;
            page_mask_reg <= '0;
        end else if (bit_evt) begin
            rx_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            case (state_reg)
                spd_pkg::SPD_DEVSEL: begin
                    if (bit_cnt_reg == 3'h7) begin
                        rw_reg <= rx_byte[`SPD_RW_BIT];
                        // Busy store stays silent so the master can poll
                        if (dev_hit && !program_busy_reg) begin
                            state_reg <= spd_pkg::SPD_ACK_DEV;
                        end else begin
                            state_reg <= spd_pkg::SPD_WAIT_STOP;
                        end
                    end
                end
                spd_pkg::SPD_ACK_DEV: begin
                    bit_cnt_reg <= 3'h0;
                    if (rw_reg) begin
                        // Prefetch; pointer then names the next byte
                        state_reg <= spd_pkg::SPD_RDATA;
                        tx_reg <= mem[ptr_reg];
                        ptr_reg <= ptr_reg + 8'h01;
                    end else begin
                        state_reg <= spd_pkg::SPD_ADDR;
                    end
                end
                spd_pkg::SPD_ADDR: begin
                    if (bit_cnt_reg == 3'h7) begin
                        ptr_reg <= rx_byte;
                        state_reg <= spd_pkg::SPD_ACK_ADDR;
                    end
                end
                spd_pkg::SPD_ACK_ADDR: begin
                    bit_cnt_reg <= 3'h0;
                    state_reg <= spd_pkg::SPD_WDATA;
                end
                spd_pkg::SPD_WDATA: begin
                    if (bit_cnt_reg == 3'h7) begin
                        state_reg <= spd_pkg::SPD_ACK_W;
                        // Protected byte acknowledged, not staged
                        if (!wp_s) begin
                            page_buf[ptr_reg[3:0]] <= rx_byte;
                            page_mask_reg[ptr_reg[3:0]] <= 1'b1;
                        end
                        // Pointer wraps inside the page
                        ptr_reg <= {ptr_reg[7:4], ptr_reg[3:0] + 4'h1};
                    end
                end
                spd_pkg::SPD_ACK_W: begin
                    bit_cnt_reg <= 3'h0;
                    state_reg <= spd_pkg::SPD_WDATA;
                end
                spd_pkg::SPD_RDATA: begin
                    tx_reg <= {tx_reg[6:0], 1'b1};
                    if (bit_cnt_reg == 3'h7) begin
                        state_reg <= spd_pkg::SPD_RACK;
                    end
                end
                spd_pkg::SPD_RACK: begin
                    bit_cnt_reg <= 3'h0;
                    // Ninth bit is the master's acknowledge
                    if (!bit_s) begin
                        state_reg <= spd_pkg::SPD_RDATA;
                        tx_reg <= mem[ptr_reg];
                        ptr_reg <= ptr_reg + 8'h01;
                    end else begin
                        state_reg <= spd_pkg::SPD_WAIT_STOP;
                    end
                end
                default: begin
                    bit_cnt_reg <= 3'h0;
                end
            endcase
        end
    end

    // Array update from staged page at the closing stop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            // Whole descriptor reloaded at reset
            for (int i = 0; i < 256; i++) begin
                mem[i] <= spd_reset_byte(8'(i));
            end
        end else if (commit) begin
            for (int i = 0; i < PAGE; i++) begin
                if (page_mask_reg[i]) begin
                    mem[{ptr_reg[7:4], 4'(i)}] <= page_buf[i];
                end
            end
        end
    end

    // Program cycle timer
    // Counted in clk cycles; the bus clock may stop meanwhile
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy_cnt_reg <= '0;
            program_busy_reg <= 1'b0;
        end else if (commit) begin
            busy_cnt_reg <= BUSY_W'(PROG_CYCLES);
            program_busy_reg <= 1'b1;
        end else if (busy_cnt_reg != '0) begin
            busy_cnt_reg <= busy_cnt_reg - BUSY_W'(1);
            program_busy_reg <= (busy_cnt_reg != BUSY_W'(1));
        end else begin
            program_busy_reg <= 1'b0;
        end
    end

    // Pad drive set only while the bus clock is low; start, stop and program cycle release it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sda_oe_reg <= 1'b0;
            sda_out_reg <= 1'b0;
        end else if (start_det || stop_det || program_busy_reg) begin
            sda_oe_reg <= 1'b0;
            sda_out_reg <= 1'b0;
        end else if (scl_fall) begin
            // Change only after a falling bus clock, never while it is high
            sda_oe_reg <= spd_pull_low(state_reg, tx_reg[7]);
            sda_out_reg <= 1'b0;
        end
    end

    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign program_busy = program_busy_reg;
endmodule : spd_serial_eeprom_slave

// [hw/spd_sync.sv]
// Two-flop level synchroniser into the clk domain.
// Assumes inputs are levels that stay stable for several clk periods.
`timescale 1ns/1ps
module spd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage1_reg <= INIT;
            stage2_reg <= INIT;
        end else begin
            stage1_reg <= d;
            stage2_reg <= stage1_reg;
        end
    end

    assign q = stage2_reg;
endmodule : spd_sync

// [sim/spd_bus_master.sv]
// Two-wire bus master model: makes SCL and pulls SDA low.
// Assumes sda_line is the resolved wire with a pull-up; SCL idles high.
`timescale 1ns/1ps
module spd_bus_master (
    output logic scl,
    output logic m_low,
    input wire logic sda_line
);
    logic lclk;
    // 32 ns pacing clock, phase unrelated to clk
    initial begin
        lclk = 1'b0;
        scl = 1'b1;
        m_low = 1'b0;
        #7.3;
        forever #16 lclk = ~lclk;
    end
    task automatic qtr();
        repeat (25) @(posedge lclk);
    endtask : qtr
    // One bit: data set in clock low, sampled midway through clock high
    task automatic bit_io(input logic b, output logic s);
        qtr();
        m_low = ~b;
        qtr();
        scl = 1'b1;
        qtr();
        s = sda_line;
        qtr();
        scl = 1'b0;
    endtask : bit_io
    task automatic send_start();
        m_low = 1'b0;
        qtr();
        scl = 1'b1;
        qtr();
        m_low = 1'b1;
        qtr();
        scl = 1'b0;
    endtask : send_start
    task automatic send_stop();
        m_low = 1'b1;
        qtr();
        scl = 1'b1;
        qtr();
        m_low = 1'b0;
        qtr();
        qtr();
    endtask : send_stop
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : wr_byte
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~mack, s);
    endtask : rd_byte
endmodule : spd_bus_master

// [sim/spd_serial_eeprom_slave_props.sv]
// Checker for the serial store slave, watching its ports only.
// Assumes a bind onto the slave; bus lines are sampled as data on clk.
`timescale 1ns/1ps
module spd_serial_eeprom_slave_props #(
    parameter int unsigned PROG_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic write_protect_pin,
    input wire logic select_addr_pin_low,
    input wire logic select_addr_pin_mid,
    input wire logic select_addr_pin_high,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic program_busy
);
    logic [31:0] busy_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Length of the current program cycle
    always_ff @(posedge clk) begin
        if (!rst_b || !program_busy) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= busy_cnt + 32'h1;
        end
    end
    a_out_low: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    a_busy_quiet: assert property (program_busy |-> !sda_oe)
        else $error("data line pulled during program cycle");
    a_busy_cap: assert property (busy_cnt <= PROG_CYCLES + 1)
        else $error("program cycle too long");
    a_busy_length: assert property ($fell(program_busy) |->
        (busy_cnt + 1 >= PROG_CYCLES) && (busy_cnt <= PROG_CYCLES + 1))
        else $error("program cycle length wrong");
    a_busy_stays: assert property ($rose(program_busy) |-> program_busy [*8])
        else $error("program cycle cut short");
    a_busy_at_stop: assert property ($rose(program_busy) |->
        scl_clk && sda_in && $past(scl_clk, 4))
        else $error("program cycle not started by stop");
    a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_clk)
        else $error("data line pulled while clock high");
    a_oe_stable_high: assert property (scl_clk && $past(scl_clk) |-> $stable(sda_oe))
        else $error("data line changed while clock high");
    a_reset_quiet: assert property ($rose(rst_b) |-> !sda_oe && !program_busy)
        else $error("outputs active after reset");
endmodule : spd_serial_eeprom_slave_props

// [sim/spd_serial_eeprom_slave_test.sv]
// Self-checking bench for the serial store slave.
// Assumes the master model and checker are compiled first.
`timescale 1ns/1ps
`define SPD_CHECK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
    $display("MISMATCH %s exp %h got %h", nm, ex, gt); n_mismatch++; end end
module spd_serial_eeprom_slave_test;
    localparam int unsigned PROG = 2000;
    localparam logic [7:0] SEL_W = 8'haa;
    localparam logic [7:0] SEL_R = 8'hab;
    logic clk, rst_b, wp, sda_oe, sda_out, busy, scl, m_low, sda_line, ack;
    logic sda_oe2, sda_out2, busy2;
    logic [7:0] d;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [7:0] exp_tbl [24] = '{8'h80, 8'h08, 8'h04, 8'h0c, 8'h0a, 8'h02, 8'h40, 8'h00,
        8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h01,
        8'h8f, 8'h04, 8'h06, 8'h01, 8'h01, 8'h00, 8'h0e, 8'h00};
    assign sda_line = (sda_oe ? sda_out : 1'b1) & (sda_oe2 ? sda_out2 : 1'b1) & ~m_low;
    spd_serial_eeprom_slave #(.PROG_CYCLES(PROG)) DUT (
        .clk(clk),
        .rst_b(rst_b),
        .scl_clk(scl),
        .sda_in(sda_line),
        .write_protect_pin(wp),
        .select_addr_pin_low(1'b1),
        .select_addr_pin_mid(1'b0),
        .select_addr_pin_high(1'b1),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .program_busy(busy)
    );
    spd_serial_eeprom_slave #(.PROG_CYCLES(PROG), .ROW_BITS_13(1'b1)) DUT2 (
        .clk(clk),
        .rst_b(rst_b),
        .scl_clk(scl),
        .sda_in(sda_line),
        .write_protect_pin(wp),
        .select_addr_pin_low(1'b0),
        .select_addr_pin_mid(1'b0),
        .select_addr_pin_high(1'b0),
        .sda_out(sda_out2),
        .sda_oe(sda_oe2),
        .program_busy(busy2)
    );
    spd_bus_master mst (.scl(scl), .m_low(m_low), .sda_line(sda_line));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic close_out();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    task automatic set_addr(input logic [7:0] a);
        mst.send_start();
        mst.wr_byte(SEL_W, ack);
        `SPD_CHECK("sel_ack", 1'b1, ack)
        mst.wr_byte(a, ack);
        `SPD_CHECK("addr_ack", 1'b1, ack)
    endtask : set_addr
    task automatic open_read();
        mst.send_start();
        mst.wr_byte(SEL_R, ack);
        `SPD_CHECK("rsel_ack", 1'b1, ack)
    endtask : open_read
    task automatic read_at(input logic [7:0] a, output logic [7:0] v);
        set_addr(a);
        open_read();
        mst.rd_byte(1'b0, v);
        mst.send_stop();
    endtask : read_at
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < PROG + 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= PROG + 100) begin
            n_mismatch++;
            close_out();
        end
    endtask : wait_idle
    task automatic t_descriptor();
        set_addr(8'h00);
        open_read();
        for (int i = 0; i < 24; i++) begin
            mst.rd_byte(i < 23, d);
            `SPD_CHECK("descriptor", exp_tbl[i], d)
        end
        mst.qtr();
        `SPD_CHECK("released", 1'b1, sda_line)
        mst.send_stop();
    endtask : t_descriptor
    task automatic t_refuse();
        mst.send_start();
        mst.wr_byte(8'h5a, ack);
        `SPD_CHECK("bad_type", 1'b0, ack)
        mst.send_stop();
        mst.send_start();
        mst.wr_byte(8'ha6, ack);
        `SPD_CHECK("bad_pins", 1'b0, ack)
        mst.send_stop();
    endtask : t_refuse
    task automatic t_byte_write();
        int polls;
        polls = 0;
        set_addr(8'h20);
        mst.wr_byte(8'h5a, ack);
        `SPD_CHECK("data_ack", 1'b1, ack)
        mst.send_stop();
        `SPD_CHECK("busy", 1'b1, busy)
        // Poll the select address until the program cycle ends
        do begin
            mst.send_start();
            mst.wr_byte(SEL_W, ack);
            mst.send_stop();
            polls++;
        end while (ack !== 1'b1 && polls < 40);
        if (ack !== 1'b1) begin
            n_mismatch++;
            close_out();
        end
        `SPD_CHECK("poll_nack", 1'b1, polls > 1)
        open_read();
        mst.rd_byte(1'b0, d);
        mst.send_stop();
        `SPD_CHECK("current_read", 8'h00, d)
        read_at(8'h20, d);
        `SPD_CHECK("byte_write", 8'h5a, d)
    endtask : t_byte_write
    task automatic t_page();
        set_addr(8'h3e);
        for (int i = 0; i < 16; i++) begin
            mst.wr_byte(8'h10 + i[7:0], ack);
            `SPD_CHECK("page_ack", 1'b1, ack)
        end
        mst.send_stop();
        wait_idle();
        set_addr(8'h30);
        open_read();
        for (int a = 0; a < 16; a++) begin
            mst.rd_byte(a < 15, d);
            `SPD_CHECK("page_wrap", (a >= 14) ? 8'h02 + a[7:0] : 8'h12 + a[7:0], d)
        end
        mst.send_stop();
    endtask : t_page
    task automatic t_variant();
        mst.send_start();
        mst.wr_byte(8'ha0, ack);
        `SPD_CHECK("alt_sel_ack", 1'b1, ack)
        mst.wr_byte(8'h03, ack);
        `SPD_CHECK("alt_addr_ack", 1'b1, ack)
        mst.send_start();
        mst.wr_byte(8'ha1, ack);
        `SPD_CHECK("alt_rsel_ack", 1'b1, ack)
        mst.rd_byte(1'b0, d);
        mst.send_stop();
        `SPD_CHECK("row_bits_13", 8'h0d, d)
        `SPD_CHECK("alt_busy", 1'b0, busy2)
    endtask : t_variant
    task automatic t_protect();
        @(posedge clk);
        #1 wp = 1'b1;
        set_addr(8'h40);
        mst.wr_byte(8'h77, ack);
        `SPD_CHECK("wp_ack", 1'b1, ack)
        mst.send_stop();
        `SPD_CHECK("wp_busy", 1'b0, busy)
        @(posedge clk);
        #1 wp = 1'b0;
        read_at(8'h40, d);
        `SPD_CHECK("wp_kept", 8'h00, d)
    endtask : t_protect
    initial begin
        rst_b = 1'b0;
        wp = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (8) @(posedge clk);
        t_descriptor();
        t_refuse();
        t_variant();
        t_byte_write();
        t_page();
        t_protect();
        close_out();
    end
endmodule : spd_serial_eeprom_slave_test
bind spd_serial_eeprom_slave spd_serial_eeprom_slave_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
    .clk(clk),
    .rst_b(rst_b),
    .scl_clk(scl_clk),
    .sda_in(sda_in),
    .write_protect_pin(write_protect_pin),
    .select_addr_pin_low(select_addr_pin_low),
    .select_addr_pin_mid(select_addr_pin_mid),
    .select_addr_pin_high(select_addr_pin_high),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .program_busy(program_busy)
);
